/* File: hdl/crc32_unit.v */
`timescale 1ns/100ps
`default_nettype none
`include "flash_map.vh"

module crc32_unit (
	input  wire        clk,
	input  wire        rst,
	input  wire        clear,
	input  wire        en,
	input  wire [7:0]  data_in,
	output wire [31:0] crc_out
);

	reg  [31:0] crc_ff;
	reg  [31:0] nxt_crc;
	integer     b;

	// Reflected CRC-32 step over one byte, LSB first.
	always @* begin
		nxt_crc = crc_ff ^ {24'h000000, data_in};
		for (b = 0; b < 8; b = b + 1) begin
			nxt_crc = nxt_crc[0] ? ((nxt_crc >> 1) ^ `CRC_POLY) : (nxt_crc >> 1);
		end
	end

	// Clear restarts the sum; enable folds one byte in.
	always @(posedge clk) begin
		if (rst || clear) begin
			crc_ff <= `CRC_INIT;
		end else if (en) begin
			crc_ff <= nxt_crc;
		end
	end

	assign crc_out = ~crc_ff;

endmodule // crc32_unit

`default_nettype wire

/* File: hdl/flash_array.v */
`timescale 1ns/100ps
`default_nettype none
`include "flash_map.vh"

module flash_array (
	input  wire        clk,
	input  wire        wr_en,
	input  wire [12:0] wr_addr,
	input  wire [7:0]  wr_data,
	input  wire [12:0] rd_a_addr,
	output wire [7:0]  rd_a_data,
	input  wire [12:0] rd_b_addr,
	output wire [7:0]  rd_b_data
);

	reg [7:0] mem [0:`FLASH_BYTES-1];
	integer   i;

	// Shipped contents: blank array with a loader stub parked at its entry point.
	initial begin
		for (i = 0; i < `FLASH_BYTES; i = i + 1) begin
			mem[i] = `ERASED_VALUE;
		end
		mem[`LOADER_ENTRY]       = 8'h80;
		mem[`LOADER_ENTRY + 1]   = 8'hFE;
	end

	// One byte is written per clock by the sequencer.
	always @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Two read ports: one for code reads, one for the CRC walk.
	assign rd_a_data = mem[rd_a_addr];
	assign rd_b_data = mem[rd_b_addr];

endmodule // flash_array

`default_nettype wire

/* File: hdl/flash_map.vh */
`ifndef FLASH_MAP_VH
`define FLASH_MAP_VH

// Register offsets on the plain register port.
`define REG_CTRL        4'h0
`define REG_DATA        4'h1
`define REG_ADDR_LO     4'h2
`define REG_ADDR_HI     4'h3
`define REG_CRC0        4'h4
`define REG_CRC1        4'h5
`define REG_CRC2        4'h6
`define REG_CRC3        4'h7
`define REG_BOOT_HI     4'h8
`define REG_CONFIG      4'h9
`define REG_BOOT_ELEM   4'hA

// Status bit positions in the control and status register.
`define ST_BUSY         0
`define ST_TIMEOUT      1
`define ST_REJECT       2

// Operation codes shared by every programming entry point.
`define CMD_NONE        4'h0
`define CMD_PROG_PAGE   4'h1
`define CMD_ERASE_BYTE  4'h2
`define CMD_ERASE_PAGE  4'h3
`define CMD_ERASE_SECT  4'h4
`define CMD_ERASE_CHIP  4'h5
`define CMD_CRC_SECT    4'h6
`define CMD_CRC_ALL     4'h7
`define CMD_LOAD_BYTE   4'h8
`define CMD_SET_BOOTVEC 4'h9
`define CMD_SET_BOOTST  4'hA

// Array geometry and fixed addresses.
`define FLASH_BYTES     8192
`define SECTOR_COUNT    8
`define PAGE_BYTES      64
`define ERASED_VALUE    8'hFF
`define BOOT_ROM_ENTRY  16'hFF00
`define APP_START       16'h0000
`define BOOT_LOW_BYTE   8'h00
`define DEFAULT_BOOTVEC 8'h1F
`define LOADER_START    13'h1E00
`define LOADER_ENTRY    13'h1F00
`define LOADER_END      13'h1FFF

// Timing: longest operation time and clock period, both in ns.
`define OP_LIMIT_NS     2000000
`define CLK_PERIOD_NS   100
`define OP_LIMIT_CYC    (`OP_LIMIT_NS / `CLK_PERIOD_NS)

// Two-wire frame length and CRC constants.
`define ICP_FRAME_BITS  6'h20
`define CRC_INIT        32'hFFFFFFFF
`define CRC_POLY        32'hEDB88320

`endif

/* File: hdl/flash_program_boot_control.v */
// Function
// - Eight 1 kB sectors of 64-byte pages.
// - 64-byte page buffer programs 1 to 64 bytes.
// - Erase byte, page, sector or whole array.
// - Internal timing; every operation ends within 2 ms.
// - Table reads denied in secured sectors only.
// - No readback verify; CRC-32 of sector or all.
// - Boot ROM call at FF00H runs selected function.
// - Control/status, data and two address registers.
// - Boot status zero starts at 0000H.
// - Non-zero status starts at vector high, 00H low.
// - Vector ships as 1FH; loader at 1E00H-1FFFH.
// - Forced loader mode acts as non-zero status.
// - Serial loader shipped in top 512 bytes.
// - Eight sector protection bytes, one per sector.
// - Configuration byte fixed at power-up.
// - Two-wire clock and data programming link.
`timescale 1ns/100ps
`default_nettype none
`include "flash_map.vh"

module flash_program_boot_control #(
	parameter OP_LIMIT = `OP_LIMIT_CYC
) (
	input  wire        clk,
	input  wire        rst,
	input  wire [3:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata,
	input  wire [12:0] code_addr,
	input  wire        code_table_read,
	output reg  [7:0]  code_rdata,
	output reg         code_denied,
	input  wire        boot_rom_program_entry,
	input  wire [15:0] rom_pc,
	input  wire [3:0]  rom_func,
	input  wire [15:0] rom_addr,
	input  wire [7:0]  rom_data,
	input  wire        icp_scl_in,
	input  wire        icp_sda_in,
	output wire        icp_sda_out,
	output wire        icp_sda_oe,
	input  wire        force_loader,
	input  wire [7:0]  user_config_flash_byte,
	input  wire [63:0] sector_security,
	output reg  [15:0] boot_addr,
	output reg  [7:0]  config_latched,
	output reg         boot_valid,
	output wire        busy
);

	localparam ST_IDLE = 1'b0;
	localparam ST_WALK = 1'b1;
	localparam integer LAST_CYC = OP_LIMIT - 1;

	reg        state_ff;
	reg [3:0]  cmd_ff;
	reg [12:0] ptr_ff;
	reg [12:0] end_ff;
	reg [14:0] limit_ff;
	reg        timeout_ff;
	reg        reject_ff;
	reg [7:0]  data_ff;
	reg [12:0] addr_ff;
	reg [7:0]  page_buf [0:`PAGE_BYTES-1];
	reg [63:0] buf_valid_ff;
	reg [7:0]  boot_vector_ff;
	reg [7:0]  boot_status_ff;
	reg [7:0]  secured_ff;
	reg [31:0] icp_shift_ff;
	reg [5:0]  icp_cnt_ff;
	reg        icp_scl_ff;
	reg        icp_sda_ff;
	reg        icp_req_ff;
	wire       busy_w;
	wire [7:0] sect_secured;
	wire [7:0] rd_code;
	wire [7:0] rd_walk;
	wire [31:0] crc_value;
	reg        req_valid;
	reg [3:0]  req_cmd;
	reg [12:0] req_addr;
	reg [7:0]  req_data;
	reg        wr_en;
	reg [7:0]  wr_data;
	wire [25:0] range;
	wire       is_erase;
	wire       is_crc;
	wire       walk_last;

	// Nonvolatile boot elements: shipped vector points at the loader.
	initial begin
		boot_vector_ff = `DEFAULT_BOOTVEC;
		boot_status_ff = 8'h01;
	end

	// Start and end address of an operation, packed {start, end}.
	function [25:0] op_range;
		input [3:0]  cmd;
		input [12:0] a;
		begin
			case (cmd)
				`CMD_PROG_PAGE, `CMD_ERASE_PAGE: op_range = {a[12:6], 6'h00, a[12:6], 6'h3F};
				`CMD_ERASE_BYTE: op_range = {a, a};
				`CMD_ERASE_SECT, `CMD_CRC_SECT: op_range = {a[12:10], 10'h000, a[12:10], 10'h3FF};
				`CMD_ERASE_CHIP, `CMD_CRC_ALL: op_range = {13'h0000, 13'h1FFF};
				default: op_range = {a, a};
			endcase
		end
	endfunction

	// A sector counts as secured when any bit of its protection byte is set.
	genvar g;
	generate
		for (g = 0; g < `SECTOR_COUNT; g = g + 1) begin : g_sec
			assign sect_secured[g] = |sector_security[8*g+7:8*g];
		end
	endgenerate

	assign busy_w    = (state_ff == ST_WALK);
	assign busy      = busy_w;
	assign is_erase  = (cmd_ff == `CMD_ERASE_BYTE) || (cmd_ff == `CMD_ERASE_PAGE) ||
	                   (cmd_ff == `CMD_ERASE_SECT) || (cmd_ff == `CMD_ERASE_CHIP);
	assign is_crc    = (cmd_ff == `CMD_CRC_SECT) || (cmd_ff == `CMD_CRC_ALL);
	assign walk_last = (ptr_ff == end_ff) || (limit_ff == LAST_CYC[14:0]);
	assign range     = op_range(req_cmd, req_addr);

	// Request selection: register port first, then boot ROM call, then two-wire link.
	always @* begin
		req_valid = 1'b0;
		req_cmd   = `CMD_NONE;
		req_addr  = addr_ff;
		req_data  = data_ff;
		if (reg_wr && reg_addr == `REG_CTRL && reg_wdata[3:0] != `CMD_NONE) begin
			req_valid = 1'b1;
			req_cmd   = reg_wdata[3:0];
		end else if (reg_wr && reg_addr == `REG_DATA) begin
			req_valid = 1'b1;
			req_cmd   = `CMD_LOAD_BYTE;
			req_data  = reg_wdata;
		end else if (boot_rom_program_entry && rom_pc == `BOOT_ROM_ENTRY) begin
			req_valid = 1'b1;
			req_cmd   = rom_func;
			req_addr  = rom_addr[12:0];
			req_data  = rom_data;
		end else if (icp_req_ff) begin
			req_valid = 1'b1;
			req_cmd   = icp_shift_ff[31:28];
			req_addr  = icp_shift_ff[20:8];
			req_data  = icp_shift_ff[7:0];
		end
	end

	// Address and data registers written by firmware.
	always @(posedge clk) begin
		if (rst) begin
			data_ff <= 8'h00;
			addr_ff <= 13'h0000;
		end else if (reg_wr) begin
			if (reg_addr == `REG_DATA) begin
				data_ff <= reg_wdata;
			end
			if (reg_addr == `REG_ADDR_LO) begin
				addr_ff[7:0] <= reg_wdata;
			end
			if (reg_addr == `REG_ADDR_HI) begin
				addr_ff[12:8] <= reg_wdata[4:0];
			end
		end
	end

	// Sequencer: walks one byte per clock over the range and times out at the limit.
	always @(posedge clk) begin
		if (rst) begin
			state_ff   <= ST_IDLE;
			cmd_ff     <= `CMD_NONE;
			ptr_ff     <= 13'h0000;
			end_ff     <= 13'h0000;
			limit_ff   <= 15'h0000;
			timeout_ff <= 1'b0;
			reject_ff  <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == `REG_CTRL && reg_wdata[7]) begin
				timeout_ff <= 1'b0;
				reject_ff  <= 1'b0;
			end
			case (state_ff)
				ST_IDLE: begin
					if (req_valid && (req_cmd <= `CMD_CRC_ALL) && req_cmd != `CMD_NONE) begin
						state_ff <= ST_WALK;
						cmd_ff   <= req_cmd;
						ptr_ff   <= range[25:13];
						end_ff   <= range[12:0];
						limit_ff <= 15'h0000;
					end
				end
				ST_WALK: begin
					if (req_valid) begin
						reject_ff <= 1'b1;
					end
					limit_ff <= limit_ff + 15'h0001;
					if (walk_last) begin
						state_ff <= ST_IDLE;
						if (ptr_ff != end_ff) begin
							timeout_ff <= 1'b1;
						end
					end else begin
						ptr_ff <= ptr_ff + 13'h0001;
					end
				end
				default: begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end

	// Page buffer loads while idle; valid marks pick which bytes get programmed.
	always @(posedge clk) begin
		if (rst) begin
			buf_valid_ff <= 64'h0;
		end else if (!busy_w && req_valid && req_cmd == `CMD_LOAD_BYTE) begin
			page_buf[req_addr[5:0]]     <= req_data;
			buf_valid_ff[req_addr[5:0]] <= 1'b1;
		end else if (busy_w && walk_last && cmd_ff == `CMD_PROG_PAGE) begin
			buf_valid_ff <= 64'h0;
		end
	end

	// Array write: erase fills, program copies only the loaded buffer bytes.
	always @* begin
		wr_en   = 1'b0;
		wr_data = `ERASED_VALUE;
		if (busy_w && is_erase) begin
			wr_en = 1'b1;
		end else if (busy_w && cmd_ff == `CMD_PROG_PAGE && buf_valid_ff[ptr_ff[5:0]]) begin
			wr_en   = 1'b1;
			wr_data = page_buf[ptr_ff[5:0]];
		end
	end

	// Boot elements are rewritten by command; a programmer clears the status.
	always @(posedge clk) begin
		if (!busy_w && req_valid && req_cmd == `CMD_SET_BOOTVEC) begin
			boot_vector_ff <= req_data;
		end
		if (!busy_w && req_valid && req_cmd == `CMD_SET_BOOTST) begin
			boot_status_ff <= req_data;
		end
	end

	// Power-up capture of start address, configuration and protection bytes.
	always @(posedge clk) begin
		if (rst) begin
			boot_valid     <= 1'b0;
			boot_addr      <= `APP_START;
			config_latched <= 8'h00;
			secured_ff     <= 8'h00;
		end else if (!boot_valid) begin
			boot_valid     <= 1'b1;
			config_latched <= user_config_flash_byte;
			secured_ff     <= sect_secured;
			if (boot_status_ff != 8'h00 || force_loader) begin
				boot_addr <= {boot_vector_ff, `BOOT_LOW_BYTE};
			end else begin
				boot_addr <= `APP_START;
			end
		end
	end

	// Code port: table reads into a secured sector return zero and flag denial.
	always @(posedge clk) begin
		if (rst) begin
			code_rdata  <= 8'h00;
			code_denied <= 1'b0;
		end else if (code_table_read && secured_ff[code_addr[12:10]]) begin
			code_rdata  <= 8'h00;
			code_denied <= 1'b1;
		end else begin
			code_rdata  <= rd_code;
			code_denied <= 1'b0;
		end
	end

	// Two-wire receiver: start on data fall with clock high, shift on clock rise.
	always @(posedge clk) begin
		if (rst) begin
			icp_scl_ff   <= 1'b1;
			icp_sda_ff   <= 1'b1;
			icp_shift_ff <= 32'h0;
			icp_cnt_ff   <= 6'h00;
			icp_req_ff   <= 1'b0;
		end else begin
			icp_scl_ff <= icp_scl_in;
			icp_sda_ff <= icp_sda_in;
			icp_req_ff <= 1'b0;
			if (icp_scl_in && icp_sda_ff && !icp_sda_in) begin
				icp_cnt_ff <= 6'h00;
			end else if (icp_scl_in && !icp_scl_ff) begin
				icp_shift_ff <= {icp_shift_ff[30:0], icp_sda_in};
				if (icp_cnt_ff == `ICP_FRAME_BITS - 6'h01) begin
					icp_cnt_ff <= 6'h00;
					icp_req_ff <= 1'b1;
				end else begin
					icp_cnt_ff <= icp_cnt_ff + 6'h01;
				end
			end
		end
	end

	// The link sees busy as the data line held low.
	assign icp_sda_out = 1'b0;
	assign icp_sda_oe  = busy_w;

	// Register read data, one cycle after the read strobe.
	always @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`REG_CTRL:      reg_rdata <= {cmd_ff, 1'b0, reject_ff, timeout_ff, busy_w};
				`REG_DATA:      reg_rdata <= data_ff;
				`REG_ADDR_LO:   reg_rdata <= addr_ff[7:0];
				`REG_ADDR_HI:   reg_rdata <= {3'h0, addr_ff[12:8]};
				`REG_CRC0:      reg_rdata <= crc_value[7:0];
				`REG_CRC1:      reg_rdata <= crc_value[15:8];
				`REG_CRC2:      reg_rdata <= crc_value[23:16];
				`REG_CRC3:      reg_rdata <= crc_value[31:24];
				`REG_BOOT_HI:   reg_rdata <= boot_addr[15:8];
				`REG_CONFIG:    reg_rdata <= config_latched;
				`REG_BOOT_ELEM: reg_rdata <= {7'h00, boot_status_ff != 8'h00};
				default:        reg_rdata <= 8'h00;
			endcase
		end
	end

	flash_array u_array (
		.clk       (clk),
		.wr_en     (wr_en),
		.wr_addr   (ptr_ff),
		.wr_data   (wr_data),
		.rd_a_addr (code_addr),
		.rd_a_data (rd_code),
		.rd_b_addr (ptr_ff),
		.rd_b_data (rd_walk)
	);

	// CRC restarts when a CRC operation launches and folds one byte per walk step.
	crc32_unit u_crc (
		.clk     (clk),
		.rst     (rst),
		.clear   (!busy_w && req_valid && (req_cmd == `CMD_CRC_SECT || req_cmd == `CMD_CRC_ALL)),
		.en      (busy_w && is_crc),
		.data_in (rd_walk),
		.crc_out (crc_value)
	);

endmodule // flash_program_boot_control

`default_nettype wire

/* File: tb/flash_program_boot_control_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
`include "flash_map.vh"

module flash_program_boot_control_monitor #(
	parameter OP_LIMIT = 9000
) (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [3:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic [12:0] code_addr,
	input wire logic        code_table_read,
	input wire logic [7:0]  code_rdata,
	input wire logic        code_denied,
	input wire logic        icp_sda_out,
	input wire logic        icp_sda_oe,
	input wire logic [7:0]  user_config_flash_byte,
	input wire logic [63:0] sector_security,
	input wire logic [15:0] boot_addr,
	input wire logic [7:0]  config_latched,
	input wire logic        boot_valid,
	input wire logic        busy
);
	logic [13:0] run_ff;
	logic        sec_hit;
	logic        cmd_wr;

	// Length of the current busy stretch; it holds the full count at the falling edge.
	always_ff @(posedge clk) begin
		if (rst || !busy)
			run_ff <= 14'h0000;
		else
			run_ff <= run_ff + 14'h0001;
	end

	// Table read into a protected sector, and a command write on the register port.
	assign sec_hit = code_table_read && (sector_security[code_addr[12:10] * 8 +: 8] != 8'h00);
	assign cmd_wr = reg_wr && reg_addr == `REG_CTRL && reg_wdata[3:0] != 4'h0;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_BYTE_ONE: assert property (cmd_wr && reg_wdata[3:0] == `CMD_ERASE_BYTE && !busy
		|=> busy ##1 !busy) else $error("byte erase busy length wrong");
	AST_LEN: assert property ($fell(busy) |-> run_ff inside {1, 64, 1024, 8192})
		else $error("busy length not a range length");
	AST_LIMIT: assert property (busy |-> run_ff < OP_LIMIT)
		else $error("operation exceeds time limit");
	AST_OE: assert property (icp_sda_oe == busy && !icp_sda_out)
		else $error("link data drive not tied to busy");
	AST_DENY: assert property (boot_valid && sec_hit |=> code_denied && code_rdata == 8'h00)
		else $error("secured table read not denied");
	AST_ALLOW: assert property (boot_valid && !sec_hit |=> !code_denied)
		else $error("allowed read denied");
	AST_BOOT_LOW: assert property (boot_valid |-> boot_addr[7:0] == `BOOT_LOW_BYTE)
		else $error("boot address low byte not zero");
	AST_CFG_CAPT: assert property ($rose(boot_valid)
		|-> config_latched == $past(user_config_flash_byte))
		else $error("config byte not captured");
	AST_CFG_HOLD: assert property (boot_valid && $past(boot_valid) |-> $stable(config_latched))
		else $error("config changed after start");
	AST_REJECT: assert property (busy && cmd_wr ##2 reg_rd && reg_addr == `REG_CTRL
		|=> reg_rdata[`ST_REJECT]) else $error("request while busy not flagged");
	AST_BOOT_RD: assert property (reg_rd && reg_addr == `REG_BOOT_HI
		|=> reg_rdata == boot_addr[15:8]) else $error("boot high byte read wrong");

	cover property ($fell(busy) && run_ff == 14'd1024);
	cover property (code_denied);
	cover property ($rose(boot_valid) && boot_addr == `APP_START);
endmodule // flash_program_boot_control_monitor

bind flash_program_boot_control flash_program_boot_control_monitor #(
	.OP_LIMIT(OP_LIMIT)
) i_mon (.*);
`default_nettype wire

/* File: tb/flash_program_boot_control_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "flash_map.vh"

module flash_program_boot_control_tb_top;
	logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, code_table_read = 1'b0;
	logic boot_rom_program_entry = 1'b0, force_loader = 1'b0;
	logic [3:0] reg_addr = 4'h0, rom_func = 4'h0;
	logic [7:0] reg_wdata = 8'h00, rom_data = 8'h00, user_config_flash_byte = 8'hA5;
	logic [12:0] code_addr = 13'h0000;
	logic [15:0] rom_pc = 16'h0000, rom_addr = 16'h0000;
	logic [63:0] sector_security = 64'h0000_0000_0100_0000;
	logic [7:0] reg_rdata, code_rdata, config_latched;
	logic [15:0] boot_addr;
	logic code_denied, icp_sda_out, icp_sda_oe, boot_valid, busy, sda_low;
	wire logic icp_scl_in, icp_sda_in;
	logic [7:0] mem [0:8191];
	int err_total = 0, total_checks = 0;

	// Open-drain data line with pull-up, shared by programmer and device.
	assign icp_sda_in = !(sda_low || (icp_sda_oe && !icp_sda_out));

	always #50 clk = ~clk;

	flash_program_boot_control #(.OP_LIMIT(9000)) i_dut (.*);
	icp_programmer_model i_prog (.clk(clk), .scl(icp_scl_in), .sda_low(sda_low));

	// Reflected CRC-32 of the model array.
	function automatic logic [31:0] crc(input int s, input int n);
		logic [31:0] c;
		c = `CRC_INIT;
		for (int i = s; i < s + n; i++) begin
			c = c ^ {24'h000000, mem[i]};
			for (int j = 0; j < 8; j++)
				c = c[0] ? (c >> 1) ^ `CRC_POLY : c >> 1;
		end
		return ~c;
	endfunction

	task automatic tally_and_finish();
		if (err_total == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// Counts busy cycles until the operation ends; a negative length skips the compare.
	task automatic wt(input int e);
		int n;
		n = 0;
		#1;
		while (busy === 1'b1 && n < 20000) begin
			n++;
			@(posedge clk);
			#1;
		end
		if (e >= 0)
			chk("busy_len", e, n);
	endtask

	task automatic sa(input logic [12:0] a);
		wr(`REG_ADDR_LO, a[7:0]);
		wr(`REG_ADDR_HI, {3'h0, a[12:8]});
	endtask

	task automatic op(input logic [3:0] c, input int e);
		wr(`REG_CTRL, {4'h0, c});
		wt(e);
	endtask

	task automatic rs();
		@(posedge clk);
		rst <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic cr(input logic [12:0] a, input logic t, input logic [7:0] e, input logic dn);
		@(posedge clk);
		code_addr <= a;
		code_table_read <= t;
		@(posedge clk);
		#1;
		chk("code_rdata", e, code_rdata);
		chk("code_denied", dn, code_denied);
	endtask

	task automatic crange(input logic [12:0] a, input int n);
		for (int i = 0; i < n; i++)
			cr(a + i[12:0], 1'b1, mem[a + i[12:0]], 1'b0);
	endtask

	task automatic rom(input logic [15:0] pc, input logic [12:0] a);
		@(posedge clk);
		rom_pc <= pc;
		rom_func <= `CMD_ERASE_BYTE;
		rom_addr <= {3'h0, a};
		rom_data <= $urandom;
		boot_rom_program_entry <= 1'b1;
		@(posedge clk);
		boot_rom_program_entry <= 1'b0;
		wt(pc == `BOOT_ROM_ENTRY ? 1 : 0);
	endtask

	task automatic rdcrc(output logic [31:0] c);
		logic [7:0] d;
		for (int j = 0; j < 4; j++) begin
			rd(`REG_CRC0 + j[3:0], d);
			c[8 * j +: 8] = d;
		end
	endtask

	// Watchdog: the sequence needs about 20000 cycles.
	initial begin
		repeat (60000) @(posedge clk);
		err_total++;
		tally_and_finish();
	end

	// Main sequence, with the expected array kept in mem.
	initial begin
		logic [7:0] d;
		logic [31:0] c;
		int k;
		k = $urandom(71435);
		for (int i = 0; i < 8192; i++)
			mem[i] = `ERASED_VALUE;
		mem[13'h1F00] = 8'h80;
		mem[13'h1F01] = 8'hFE;
		rs();
		chk("boot_addr", 16'h1F00, boot_addr);
		user_config_flash_byte <= 8'h3C;
		rd(`REG_CONFIG, d);
		chk("config", 8'hA5, d);
		crange(13'h1F00, 2);
		cr(13'h0C00, 1'b1, 8'h00, 1'b1);
		cr(13'h0C00, 1'b0, mem[13'h0C00], 1'b0);
		cr(13'h0BFF, 1'b1, mem[13'h0BFF], 1'b0);
		k = 6 + $urandom % 59;
		sa(13'h0800);
		for (int i = 0; i < k; i++) begin
			d = $urandom;
			mem[13'h0800 + i] = d;
			wr(`REG_ADDR_LO, i[7:0]);
			wr(`REG_DATA, d);
		end
		op(`CMD_PROG_PAGE, 64);
		crange(13'h0800, 64);
		d = $urandom;
		i_prog.send(`CMD_LOAD_BYTE, 13'h0845, d);
		i_prog.send(`CMD_PROG_PAGE, 13'h0845, 8'h00);
		wt(-1);
		mem[13'h0845] = d;
		crange(13'h0840, 64);
		sa(13'h0800);
		op(`CMD_ERASE_BYTE, 1);
		rom(16'hFF01, 13'h0802);
		rom(16'hFF00, 13'h0801);
		mem[13'h0800] = 8'hFF;
		mem[13'h0801] = 8'hFF;
		crange(13'h0800, 4);
		sa(13'h0A00);
		op(`CMD_CRC_SECT, 1024);
		rdcrc(c);
		chk("crc_sector", crc(13'h0800, 1024), c);
		sa(13'h0800);
		op(`CMD_ERASE_PAGE, 64);
		for (int i = 0; i < 64; i++)
			mem[13'h0800 + i] = 8'hFF;
		crange(13'h07FF, 71);
		sa(13'h0BFF);
		op(`CMD_ERASE_SECT, 1024);
		mem[13'h0845] = 8'hFF;
		crange(13'h0840, 8);
		wr(`REG_DATA, 8'h05);
		op(`CMD_SET_BOOTVEC, -1);
		rs();
		chk("boot_addr", 16'h0500, boot_addr);
		i_prog.send(`CMD_SET_BOOTST, 13'h0000, 8'h00);
		wt(-1);
		rs();
		chk("boot_addr", 16'h0000, boot_addr);
		force_loader <= 1'b1;
		rs();
		chk("boot_addr", 16'h0500, boot_addr);
		rd(`REG_BOOT_HI, d);
		chk("boot_hi", 8'h05, d);
		wr(`REG_CTRL, {4'h0, `CMD_ERASE_CHIP});
		wr(`REG_CTRL, {4'h0, `CMD_ERASE_BYTE});
		rd(`REG_CTRL, d);
		chk("ctrl_busy", 8'h05, {4'h0, d[3:0]});
		wr(`REG_CTRL, 8'h80);
		wt(-1);
		rd(`REG_CTRL, d);
		chk("ctrl_idle", 8'h00, {4'h0, d[3:0]});
		for (int i = 0; i < 8192; i++)
			mem[i] = 8'hFF;
		op(`CMD_CRC_ALL, 8192);
		rdcrc(c);
		chk("crc_all", crc(0, 8192), c);
		crange(13'h1F00, 2);
		tally_and_finish();
	end
endmodule // flash_program_boot_control_tb_top
`default_nettype wire

/* File: tb/icp_programmer_model.sv */
`timescale 1ns/100ps
`default_nettype none

module icp_programmer_model (
	input  wire logic clk,
	output var  logic scl,
	output var  logic sda_low
);
	// Idle: clock stands high, data released to its pull-up.
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// Spacing between line changes, in system clocks.
	task automatic gap();
		repeat (3) @(posedge clk);
	endtask

	// Start condition, then 32 bits with the most significant first.
	task automatic send(input logic [3:0] cmd, input logic [12:0] addr, input logic [7:0] data);
		logic [31:0] f;
		f = {cmd, 7'h55, addr, data};
		sda_low <= 1'b1;
		gap();
		for (int i = 31; i >= 0; i--) begin
			scl <= 1'b0;
			gap();
			sda_low <= !f[i];
			gap();
			scl <= 1'b1;
			gap();
		end
		scl <= 1'b0;
		gap();
		sda_low <= 1'b0;
		gap();
		scl <= 1'b1;
		gap();
	endtask
endmodule // icp_programmer_model
`default_nettype wire
